// ### sac_pkg.sv
// Overview of operation
// - Mode pin low picks parallel, high serial.
// - Six binary weights, 0.5 to 16 dB.
// - Latched parallel: strobe pulse captures weight inputs.
// - Strobe held high: attenuation follows weight inputs.
// - Serial bits shift in regardless of strobe.
// - Strobe high passes shift word; low holds.
// - Serial word arrives most significant bit first.
// - Serial data sampled on serial clock rise.
// - Serial power-up loads the weight inputs.
// - Parallel power-up, strobe low: select table.
// - Parallel power-up, strobe high: weight inputs.
// - Undriven strobe reads high.
package sac_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int WORD_W = 6;
   localparam int PIN_W  = 10;
   localparam int LINK_CNT_W = 4;

   // ****************************************
   // Pin vector field positions
   // ****************************************
   localparam int PIN_MODE   = 9;
   localparam int PIN_STROBE = 8;
   localparam int PIN_PUPMSB = 7;
   localparam int PIN_PUPLSB = 6;
   localparam logic [PIN_W-1:0] PIN_RESET = 10'h100;

   // ****************************************
   // Power-up words
   // ****************************************
   localparam logic [WORD_W-1:0] PUP_REF  = 6'h00;
   localparam logic [WORD_W-1:0] PUP_8DB  = 6'h10;
   localparam logic [WORD_W-1:0] PUP_16DB = 6'h20;
   localparam logic [WORD_W-1:0] PUP_31DB = 6'h3e;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;
   localparam logic [7:0]  ADDR_SHIFT  = 8'h08;
   localparam int          CTRL_FREEZE = 0;
   localparam int          CTRL_RELOAD = 1;
   localparam int          ST_MODE     = 8;
   localparam int          ST_STROBE   = 9;
   localparam int          ST_SVALID   = 10;
   localparam int          ST_PUDONE   = 11;

   // ****************************************
   // Timing
   // ****************************************
   localparam int          CLK_NS        = 40;
   localparam int          SER_STROBE_NS = 30;
   localparam int          STROBE_MIN_CYC = (SER_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0]  PU_WAIT       = 2'h3;
   localparam logic [1:0]  QUIET_CYC     = 2'h2;

   typedef enum logic [1:0] {SAC_PU_WAIT, SAC_RUN} sac_phase_t;

endpackage : sac_pkg

// ### sac_step_atten.sv
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module sac_step_atten
   import sac_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              parSerSelect,
   input  wire logic              latchStrobe,
   input  wire logic              weightBitSixteen,
   input  wire logic              weightBitEight,
   input  wire logic              weightBitFour,
   input  wire logic              weightBitTwo,
   input  wire logic              weightBitOne,
   input  wire logic              weightBitHalf,
   input  wire logic              powerupSelectMsb,
   input  wire logic              powerupSelectLsb,
   input  wire logic              serialClk,
   input  wire logic              serialData,
   output logic      [WORD_W-1:0] attenWord
);

   // ****************************************
   // Power-up decode
   // ****************************************
   function automatic logic [WORD_W-1:0] pupDecode(input logic msb, input logic lsb);
      unique case ({msb, lsb})
         2'b00:   pupDecode = PUP_REF;
         2'b01:   pupDecode = PUP_8DB;
         2'b10:   pupDecode = PUP_16DB;
         default: pupDecode = PUP_31DB;
      endcase
   endfunction : pupDecode

   // ****************************************
   // Link domain
   // ****************************************
   logic [1:0]            linkRstSync_reg;
   logic [WORD_W-1:0]     shift_reg;
   logic [LINK_CNT_W-1:0] shiftCnt_reg;
   logic [LINK_CNT_W-1:0] shiftGray_reg;
   logic [LINK_CNT_W-1:0] shiftCntInc;

   assign shiftCntInc = shiftCnt_reg + 4'h1;

   always_ff @(posedge serialClk) begin
      linkRstSync_reg <= {linkRstSync_reg[0], rstn};
   end

   // The shift register has no reset, so a frame that follows reset release is taken whole.
   always_ff @(posedge serialClk) begin
      shift_reg <= {shift_reg[WORD_W-2:0], serialData};
   end

   // A gray count of link edges crosses safely; a toggle would look unchanged after an
   // even number of edges inside one system clock period.
   always_ff @(posedge serialClk) begin
      if (!linkRstSync_reg[1]) begin
         shiftCnt_reg  <= 4'h0;
         shiftGray_reg <= 4'h0;
      end else begin
         shiftCnt_reg  <= shiftCntInc;
         shiftGray_reg <= shiftCntInc ^ (shiftCntInc >> 1);
      end
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [PIN_W-1:0]  pinRaw;
   logic [PIN_W-1:0]  pinMeta_reg;
   logic [PIN_W-1:0]  pin_reg;
   logic [WORD_W-1:0] wordMeta_reg;
   logic [WORD_W-1:0] wordSync_reg;
   logic [LINK_CNT_W-1:0] cntMeta_reg;
   logic [LINK_CNT_W-1:0] cntSync_reg;

   assign pinRaw = {parSerSelect, latchStrobe, powerupSelectMsb, powerupSelectLsb,
                    weightBitSixteen, weightBitEight, weightBitFour,
                    weightBitTwo, weightBitOne, weightBitHalf};

   // Pins are asynchronous to clk; the strobe resets high, as an undriven pin would read.
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : gPinSync
         always_ff @(posedge clk) begin
            if (!rstn) begin
               pinMeta_reg[gi] <= PIN_RESET[gi];
               pin_reg[gi]     <= PIN_RESET[gi];
            end else begin
               pinMeta_reg[gi] <= pinRaw[gi];
               pin_reg[gi]     <= pinMeta_reg[gi];
            end
         end
      end
      for (gi = 0; gi < WORD_W; gi++) begin : gWordSync
         always_ff @(posedge clk) begin
            if (!rstn) begin
               wordMeta_reg[gi] <= 1'b0;
               wordSync_reg[gi] <= 1'b0;
            end else begin
               wordMeta_reg[gi] <= shift_reg[gi];
               wordSync_reg[gi] <= wordMeta_reg[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cntMeta_reg <= 4'h0;
         cntSync_reg <= 4'h0;
      end else begin
         cntMeta_reg <= shiftGray_reg;
         cntSync_reg <= cntMeta_reg;
      end
   end

   logic              modeSerial;
   logic              strobeHigh;
   logic [WORD_W-1:0] parWord;

   assign modeSerial = pin_reg[PIN_MODE];
   assign strobeHigh = pin_reg[PIN_STROBE];
   assign parWord    = pin_reg[WORD_W-1:0];

   // ****************************************
   // Serial word capture
   // ****************************************
   // The word is taken only once the shift count has been quiet for a while, so
   // that every bit has settled through its synchroniser together.
   // A run of exactly sixteen edges between two samples would go unseen.
   logic [LINK_CNT_W-1:0] cntPrev_reg;
   logic [1:0]        quiet_reg;
   logic [WORD_W-1:0] serialWord_reg;
   logic              serialValid_reg;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cntPrev_reg <= 4'h0;
         quiet_reg   <= 2'h3;
      end else begin
         cntPrev_reg <= cntSync_reg;
         if (cntSync_reg != cntPrev_reg) begin
            quiet_reg <= 2'h0;
         end else if (quiet_reg != 2'h3) begin
            quiet_reg <= quiet_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         serialWord_reg  <= 6'h00;
         serialValid_reg <= 1'b0;
      end else if (quiet_reg == QUIET_CYC) begin
         serialWord_reg  <= wordSync_reg;
         serialValid_reg <= 1'b1;
      end
   end

   // ****************************************
   // Register interface
   // ****************************************
   logic              ctrlFreeze_reg;
   logic              reloadPulse_reg;
   logic              wrPending_reg;
   logic [7:0]        wrAddr_reg;
   logic [31:0]       rdData_reg;
   logic              puDone;
   logic              addrPhase;
   logic [31:0]       statusWord;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdData_reg;
   assign addrPhase = hsel && hready && htrans[1];
   assign statusWord = {20'h00000, puDone, serialValid_reg, strobeHigh, modeSerial,
                        2'h0, attenWord};

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wrPending_reg <= 1'b0;
         wrAddr_reg    <= 8'h00;
      end else begin
         wrPending_reg <= addrPhase && hwrite;
         wrAddr_reg    <= haddr[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdData_reg <= 32'h00000000;
      end else if (addrPhase && !hwrite) begin
         unique case (haddr[7:0])
            ADDR_CTRL:   rdData_reg <= {30'h0, 1'b0, ctrlFreeze_reg};
            ADDR_STATUS: rdData_reg <= statusWord;
            ADDR_SHIFT:  rdData_reg <= {26'h0, serialWord_reg};
            default:     rdData_reg <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrlFreeze_reg  <= 1'b0;
         reloadPulse_reg <= 1'b0;
      end else begin
         reloadPulse_reg <= 1'b0;
         if (wrPending_reg && wrAddr_reg == ADDR_CTRL) begin
            ctrlFreeze_reg  <= hwdata[CTRL_FREEZE];
            reloadPulse_reg <= hwdata[CTRL_RELOAD];
         end
      end
   end

   // ****************************************
   // Power-up sequencing
   // ****************************************
   // The pins are only trusted once they have passed the synchronisers after release.
   sac_phase_t phase_reg;
   logic [1:0] puCnt_reg;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         phase_reg <= SAC_PU_WAIT;
         puCnt_reg <= PU_WAIT;
      end else begin
         unique case (phase_reg)
            SAC_PU_WAIT: begin
               puCnt_reg <= puCnt_reg - 2'h1;
               if (puCnt_reg == 2'h1) begin
                  phase_reg <= SAC_RUN;
               end
            end
            SAC_RUN: begin
               if (reloadPulse_reg) begin
                  phase_reg <= SAC_PU_WAIT;
                  puCnt_reg <= PU_WAIT;
               end
            end
         endcase
      end
   end

   assign puDone = (phase_reg == SAC_RUN);

   // ****************************************
   // Attenuation latch
   // ****************************************
   logic [WORD_W-1:0] atten_reg;
   logic [WORD_W-1:0] atten_next;

   always_comb begin
      atten_next = atten_reg;
      if (phase_reg == SAC_PU_WAIT && puCnt_reg == 2'h1) begin
         if (modeSerial) begin
            atten_next = parWord;
         end else if (!strobeHigh) begin
            atten_next = pupDecode(pin_reg[PIN_PUPMSB], pin_reg[PIN_PUPLSB]);
         end else begin
            atten_next = parWord;
         end
      end else if (phase_reg == SAC_RUN && !ctrlFreeze_reg && strobeHigh) begin
         if (!modeSerial) begin
            atten_next = parWord;
         end else if (serialValid_reg) begin
            atten_next = serialWord_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         atten_reg <= PUP_REF;
      end else begin
         atten_reg <= atten_next;
      end
   end

   assign attenWord = atten_reg;

endmodule : sac_step_atten

// ### sac_step_atten_checker.sv
`timescale 1ns/1ps
module sac_step_atten_checker
   import sac_pkg::*;
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              parSerSelect,
   input wire logic              latchStrobe,
   input wire logic              weightBitSixteen,
   input wire logic              weightBitEight,
   input wire logic              weightBitFour,
   input wire logic              weightBitTwo,
   input wire logic              weightBitOne,
   input wire logic              weightBitHalf,
   input wire logic              powerupSelectMsb,
   input wire logic              powerupSelectLsb,
   input wire logic [WORD_W-1:0] attenWord
);
   // ****************************************
   // Helpers
   // ****************************************
   // Counts cycles after reset so the power-up load is not taken for a stray change.
   logic [2:0]        puCnt;
   logic [WORD_W-1:0] wvec;
   logic [WORD_W-1:0] pupWord;
   assign wvec = {weightBitSixteen, weightBitEight, weightBitFour, weightBitTwo, weightBitOne, weightBitHalf};
   assign pupWord = powerupSelectMsb ? (powerupSelectLsb ? PUP_31DB : PUP_16DB)
                                     : (powerupSelectLsb ? PUP_8DB : PUP_REF);
   always_ff @(posedge clk) begin
      if (!rstn) puCnt <= 3'h0;
      else if (puCnt != 3'h7) puCnt <= puCnt + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence sHeldLow;
      (!latchStrobe && puCnt == 3'h7) [*4];
   endsequence
   sequence sDirect;
      (!parSerSelect && latchStrobe && $stable(wvec) && puCnt == 3'h7) [*4];
   endsequence
   sequence sPulseEnd;
      (!parSerSelect && latchStrobe) [*2] ##1 (!latchStrobe && puCnt == 3'h7);
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   AST_HOLD: assert property (sHeldLow |=> $stable(attenWord))
      else $error("attenWord moved while strobe low");
   AST_DIRECT: assert property (sDirect |-> attenWord == wvec)
      else $error("attenWord does not follow weights");
   AST_LATCH: assert property (sPulseEnd |-> ##2 attenWord == $past(wvec, 3))
      else $error("strobe pulse did not capture weights");
   AST_PUP_LOW: assert property (puCnt == 3'h5 && !parSerSelect && !latchStrobe |-> attenWord == pupWord)
      else $error("power-up select word wrong");
   AST_PUP_SER: assert property (puCnt == 3'h5 && parSerSelect |-> attenWord == wvec)
      else $error("serial power-up word wrong");
   AST_PUP_HI: assert property (puCnt == 3'h5 && !parSerSelect && latchStrobe |-> attenWord == wvec)
      else $error("parallel power-up word wrong");
   AST_CHANGE: assert property ($changed(attenWord) && puCnt == 3'h7 |->
                                $past(latchStrobe, 2) || $past(latchStrobe, 3) || $past(latchStrobe, 4))
      else $error("attenWord changed without strobe");
   AST_RESET: assert property ($rose(rstn) |-> attenWord == 6'h00)
      else $error("attenWord not cleared by reset");
endmodule : sac_step_atten_checker

bind sac_step_atten sac_step_atten_checker chk (.clk(clk), .rstn(rstn), .parSerSelect(parSerSelect),
   .latchStrobe(latchStrobe), .weightBitSixteen(weightBitSixteen), .weightBitEight(weightBitEight),
   .weightBitFour(weightBitFour), .weightBitTwo(weightBitTwo), .weightBitOne(weightBitOne),
   .weightBitHalf(weightBitHalf), .powerupSelectMsb(powerupSelectMsb),
   .powerupSelectLsb(powerupSelectLsb), .attenWord(attenWord));

// ### sac_host_model.sv
`timescale 1ns/1ps
module sac_host_model (
   output logic serialClk,
   output logic serialData
);
   // The serial clock stands low between frames; the data line is inverted once released.
   initial begin
      serialClk = 1'b0;
      serialData = 1'b1;
   end
   task automatic send(input logic [5:0] word);
      for (int i = 5; i >= 0; i--) begin
         serialData = word[i];
         #3 serialClk = 1'b1;
         #3 serialClk = 1'b0;
      end
      #3 serialData = ~word[0];
   endtask : send
endmodule : sac_host_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
   import sac_pkg::*;
;
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   logic              hsel = 1'b0;
   logic [31:0]       haddr = 32'h0;
   logic [1:0]        htrans = 2'h0;
   logic              hwrite = 1'b0;
   logic [31:0]       hwdata = 32'h0;
   logic [31:0]       hrdata;
   logic              hreadyout;
   logic              parSerSelect = 1'b0;
   logic              latchStrobe = 1'b0;
   logic [WORD_W-1:0] weights = 6'h00;
   logic [1:0]        pupSel = 2'h0;
   logic              serialClk;
   logic              serialData;
   logic [WORD_W-1:0] attenWord;
   logic [31:0]       rdData;
   int                num_errors = 0;
   int                cmp_count = 0;
   logic [WORD_W-1:0] pupExp [4] = '{PUP_REF, PUP_8DB, PUP_16DB, PUP_31DB};
   logic [WORD_W-1:0] codes [9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3f, 6'h2a};
   // Successive settings stand 40 us apart, the slowest switching rate of the attenuator.
   localparam int     SETTLE_CYC = 1000;
   always #20 clk = ~clk;
   sac_step_atten DUT (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
      .parSerSelect(parSerSelect), .latchStrobe(latchStrobe), .weightBitSixteen(weights[5]),
      .weightBitEight(weights[4]), .weightBitFour(weights[3]), .weightBitTwo(weights[2]),
      .weightBitOne(weights[1]), .weightBitHalf(weights[0]), .powerupSelectMsb(pupSel[1]),
      .powerupSelectLsb(pupSel[0]), .serialClk(serialClk), .serialData(serialData), .attenWord(attenWord));
   sac_host_model host (.serialClk(serialClk), .serialData(serialData));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
   endtask : wait_ready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rdData = hrdata;
   endtask : bus
   // Outputs are compared at the falling edge, clear of the register updates.
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : wait_cyc
   task automatic set_pins(input logic m, input logic s, input logic [5:0] w, input logic [1:0] p);
      @(posedge clk);
      parSerSelect <= m;
      latchStrobe <= s;
      weights <= w;
      pupSel <= p;
   endtask : set_pins
   task automatic do_reset(input logic m, input logic s, input logic [5:0] w, input logic [1:0] p);
      set_pins(m, s, w, p);
      @(posedge clk);
      rstn <= 1'b0;
      host.send(6'h00);
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      wait_cyc(6);
   endtask : do_reset
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      for (int i = 0; i < 4; i++) begin
         do_reset(1'b0, 1'b0, 6'h2d, i[1:0]);
         check("powerup select word", {26'h0, pupExp[i]}, {26'h0, attenWord});
      end
      do_reset(1'b1, 1'b0, 6'h2d, 2'h3);
      check("serial powerup word", 32'h2d, {26'h0, attenWord});
      do_reset(1'b0, 1'b1, 6'h15, 2'h3);
      check("parallel powerup word", 32'h15, {26'h0, attenWord});
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("status word", (32'h1 << ST_PUDONE) | (32'h1 << ST_STROBE) | 32'h15, rdData);
      bus(1'b0, 8'h0c, 32'h0);
      check("unmapped read", 32'h0, rdData);
      bus(1'b1, ADDR_CTRL, 32'h1 << CTRL_FREEZE);
      bus(1'b0, ADDR_CTRL, 32'h0);
      check("control freeze read", 32'h1 << CTRL_FREEZE, rdData);
      bus(1'b1, ADDR_CTRL, 32'h0);
      bus(1'b0, ADDR_CTRL, 32'h0);
      check("control read", 32'h0, rdData);
      for (int i = 0; i < 9; i++) begin
         set_pins(1'b0, 1'b1, codes[i], 2'h3);
         wait_cyc(4);
         check("direct word", {26'h0, codes[i]}, {26'h0, attenWord});
         wait_cyc(SETTLE_CYC);
      end
      set_pins(1'b0, 1'b0, 6'h15, 2'h3);
      wait_cyc(4);
      check("latched hold", 32'h2a, {26'h0, attenWord});
      set_pins(1'b0, 1'b1, 6'h15, 2'h3);
      wait_cyc(1);
      set_pins(1'b0, 1'b0, 6'h15, 2'h3);
      wait_cyc(4);
      check("latched word", 32'h15, {26'h0, attenWord});
      set_pins(1'b1, 1'b0, 6'h15, 2'h3);
      host.send(6'h2b);
      wait_cyc(8);
      check("held during entry", 32'h15, {26'h0, attenWord});
      bus(1'b0, ADDR_SHIFT, 32'h0);
      check("shift word", 32'h2b, rdData);
      set_pins(1'b1, 1'b1, 6'h15, 2'h3);
      wait_cyc(1);
      set_pins(1'b1, 1'b0, 6'h15, 2'h3);
      wait_cyc(4);
      check("serial latched word", 32'h2b, {26'h0, attenWord});
      set_pins(1'b1, 1'b1, 6'h15, 2'h3);
      host.send(6'h1c);
      wait_cyc(8);
      check("transparent shift", 32'h1c, {26'h0, attenWord});
      set_pins(1'b1, 1'b1, 6'h3f, 2'h3);
      wait_cyc(4);
      check("serial ignores weights", 32'h1c, {26'h0, attenWord});
      end_of_test();
   end
endmodule : tb_top
